// [rtl/ddslc_lock_ctrl.sv]
// Contract
// [R1] bypass input picks immediate or two-byte-delayed lock-on
// [R2] controller holds bypass low for hard sectors
// [R3] idle loop runs high rate, ratio two
// [R4] lock output low after two preamble bytes
// [R5] controller loops lock output to commit input
// [R6] commit selects low rate and decoded output
// [R7] commit moves read clock to data rate
// [R8] no preamble: no lock, decode, absent flag
// [R9] controller retries read gate after timeout
// [R10] polarity input picks zeroes or ones preamble
// [R11] external decoder samples raw data on recovered clock
// [R12] delayed variant compares frequency until locked
// [R13] comparator select follows gate or lock per variant
// [R14] controller keeps reference clock running
// [R15] encoded data decoded to serial data and clock
// [R16] gate release clears lock and restores rates
`include "ddslc_regs.svh"
`default_nettype none
module ddslc_lock_ctrl
   import ddslc_pkg::*;
#(
   parameter int DELAY_BYTES = `DDSLC_DELAY_BYTES,
   parameter int LOCK_BYTES = `DDSLC_LOCK_BYTES,
   parameter bit SEL_ON_GATE = 1'b1
) (
   // clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // controller side
   input wire logic read_gate,
   input wire logic lock_commit,
   input wire ddslc_cfg_s cfg,
   // encoded stream, one cell per strobe on the recovered clock
   input wire logic cell_valid,
   input wire logic cell_bit,
   // status
   output var ddslc_stat_s stat,
   output logic [1:0] freq_ratio,
   // data outputs
   output logic sync_data,
   output logic read_clk,
   output logic read_data,
   output logic absent_clock_flag
);
   localparam logic [7:0] DELAY_CELLS = 8'(DELAY_BYTES * `DDSLC_CELLS_PER_BYTE);
   localparam logic [7:0] LOCK_CELLS = 8'(LOCK_BYTES * `DDSLC_CELLS_PER_BYTE);

   ddslc_reg_s cur_ff, nxt_cur;
   logic expect_bit, data_cell, commit_act;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      // zeroes preamble: clock cells 1, data cells 0; ones preamble the reverse
      expect_bit = cur_ff.phase ^ ~cfg.preamble_polarity_select; // R10
      data_cell = cur_ff.phase;
      commit_act = read_gate && lock_commit;
      nxt_cur = cur_ff;
      if (clk_en) begin
         if (cell_valid) begin
            nxt_cur.phase = ~cur_ff.phase;
            nxt_cur.sync_data = cell_bit;
            // kept in every state so the first clock cell after commit
            // is judged against a real data cell, not a stale reset value
            if (data_cell) begin
               nxt_cur.prev_data = cell_bit; // R8
            end
         end
         case (cur_ff.st)
            DDSLC_IDLE: begin
               nxt_cur.lock_n = 1'b1;
               nxt_cur.cnt = '0;
               if (read_gate) begin
                  nxt_cur.st = cfg.delay_bypass ? DDSLC_ACQUIRE : DDSLC_DELAY; // R1
               end
            end
            DDSLC_DELAY: begin
               // gap bits after the sector pulse are not chased
               if (cell_valid) begin
                  nxt_cur.cnt = cur_ff.cnt + 8'h01;
                  if (cur_ff.cnt == DELAY_CELLS - 8'h01) begin
                     nxt_cur.st = DDSLC_ACQUIRE; // R1
                     nxt_cur.cnt = '0;
                  end
               end
            end
            DDSLC_ACQUIRE: begin
               if (cell_valid) begin
                  if (cell_bit == expect_bit) begin
                     nxt_cur.cnt = cur_ff.cnt + 8'h01;
                     if (cur_ff.cnt == LOCK_CELLS - 8'h01) begin
                        nxt_cur.st = DDSLC_LOCKED; // R4
                        nxt_cur.lock_n = 1'b0;
                     end
                  end else begin
                     // slip one cell so the clock/data phase can realign;
                     // non-preamble data keeps restarting the count
                     nxt_cur.phase = cur_ff.phase; // R8
                     nxt_cur.cnt = '0;
                  end
               end
            end
            DDSLC_LOCKED: begin
               if (lock_commit) begin
                  nxt_cur.st = DDSLC_TRACK; // R6
               end
            end
            DDSLC_TRACK: begin
               if (cell_valid && data_cell) begin
                  nxt_cur.read_data = cell_bit; // R15
               end
            end
            default: nxt_cur.st = DDSLC_IDLE;
         endcase
         // read clock: half reference rate, one period per data cell once tracking
         if (cur_ff.st == DDSLC_TRACK && commit_act) begin
            if (cell_valid) begin
               nxt_cur.read_clk = data_cell; // R7
            end
         end else begin
            nxt_cur.read_clk = ~cur_ff.read_clk; // R7
         end
         // missing clock: clock cell zero right after a zero data cell
         nxt_cur.absent = cur_ff.st == DDSLC_TRACK && cell_valid && !data_cell &&
                          !cell_bit && !cur_ff.prev_data && !cur_ff.read_data; // R8
         if (!read_gate) begin
            nxt_cur.st = DDSLC_IDLE; // R16
            nxt_cur.lock_n = 1'b1; // R16
            nxt_cur.cnt = '0;
            nxt_cur.absent = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur_ff <= '{st: DDSLC_IDLE, cnt: 8'h00, phase: 1'b0, lock_n: 1'b1,
                     read_clk: 1'b0, read_data: 1'b0, sync_data: 1'b0,
                     prev_data: 1'b0, absent: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      stat.lock_n = cur_ff.lock_n; // R4
      // low rate only once commit is taken inside a read
      stat.high_track_rate = !(commit_act && cur_ff.st == DDSLC_TRACK); // R3 R6
      stat.cmp_sel_a = SEL_ON_GATE ? read_gate : !cur_ff.lock_n; // R13
      // frequency comparison kept alive until the preamble bytes are seen
      stat.freq_compare_en = cur_ff.lock_n; // R12
      freq_ratio = stat.high_track_rate ? 2'(`DDSLC_RATIO_IDLE) : 2'h0; // R3
   end
   assign sync_data = cur_ff.sync_data; // R11
   assign read_clk = cur_ff.read_clk;
   assign read_data = cur_ff.read_data;
   assign absent_clock_flag = cur_ff.absent;

   ////////////////////////////////////////////////////////////////////
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_gate_rise;
      clk_en && read_gate && cur_ff.st == DDSLC_IDLE;
   endsequence
   sequence s_lock_fall;
      $fell(cur_ff.lock_n);
   endsequence
   sequence s_delay_end;
      clk_en && read_gate && cur_ff.st == DDSLC_DELAY && cell_valid &&
      cur_ff.cnt == DELAY_CELLS - 8'h01;
   endsequence

   a_bypass_start: assert property ( // R1
      (s_gate_rise and cfg.delay_bypass) |=> cur_ff.st == DDSLC_ACQUIRE)
      else $error("bypass did not start acquisition at once");
   a_delay_wait: assert property ( // R1
      (s_gate_rise and !cfg.delay_bypass) |=> cur_ff.st == DDSLC_DELAY)
      else $error("delayed lock-on skipped the gap");
   a_delay_end: assert property ( // R1
      s_delay_end |=> cur_ff.st == DDSLC_ACQUIRE && cur_ff.cnt == 8'h00)
      else $error("delay did not end after the gap bytes");
   a_idle_rate: assert property ( // R3
      !read_gate |-> stat.high_track_rate && freq_ratio == 2'h2)
      else $error("idle loop not at high rate");
   a_lock_count: assert property ( // R4
      s_lock_fall |-> $past(cur_ff.st) == DDSLC_ACQUIRE &&
      $past(cur_ff.cnt) == LOCK_CELLS - 8'h01)
      else $error("lock reported before two preamble bytes");
   a_commit_track: assert property ( // R6
      clk_en && read_gate && cur_ff.st == DDSLC_LOCKED && lock_commit
      |=> cur_ff.st == DDSLC_TRACK ##0 !stat.high_track_rate)
      else $error("commit did not switch to low rate");
   a_nolock_quiet: assert property ( // R8
      cur_ff.lock_n |-> !absent_clock_flag && cur_ff.st != DDSLC_TRACK)
      else $error("activity without lock");
   // frequency compare must stay on through the whole acquisition
   a_freq_until: assert property ( // R12
      cur_ff.st inside {DDSLC_IDLE, DDSLC_DELAY, DDSLC_ACQUIRE} |-> stat.freq_compare_en)
      else $error("frequency compare dropped before lock");
   a_lock_stands: assert property ( // R4
      clk_en && read_gate && !cur_ff.lock_n |=> !cur_ff.lock_n)
      else $error("lock indication dropped during read");
   a_slip_restart: assert property ( // R10
      clk_en && read_gate && cur_ff.st == DDSLC_ACQUIRE && cell_valid && cell_bit != expect_bit
      |=> cur_ff.cnt == 8'h00 && cur_ff.phase == $past(cur_ff.phase))
      else $error("mismatched cell did not restart the count");
   a_track_decode: assert property ( // R15
      clk_en && read_gate && cur_ff.st == DDSLC_TRACK && cell_valid && data_cell
      |=> read_data == $past(cell_bit))
      else $error("data cell not decoded");
   a_rclk_rate: assert property ( // R7
      clk_en && commit_act && cur_ff.st == DDSLC_TRACK && cell_valid
      |=> read_clk == $past(data_cell))
      else $error("read clock not following data cells");
   a_flag_track: assert property ( // R8
      absent_clock_flag |-> $past(cur_ff.st) == DDSLC_TRACK)
      else $error("missing clock flag outside tracking");
   a_sel_a: assert property ( // R13
      SEL_ON_GATE ? stat.cmp_sel_a == read_gate : stat.cmp_sel_a == !stat.lock_n)
      else $error("comparator select wrong");
   a_gate_drop: assert property ( // R16
      clk_en && !read_gate |=> cur_ff.lock_n && cur_ff.st == DDSLC_IDLE)
      else $error("gate drop did not clear lock");
   a_half_clk: assert property ( // R7
      clk_en && cur_ff.st != DDSLC_TRACK |=> read_clk != $past(read_clk))
      else $error("read clock not at half reference rate");
endmodule
`default_nettype wire

// [rtl/ddslc_regs.svh]
`ifndef DDSLC_REGS_SVH
`define DDSLC_REGS_SVH
// encoded cells per byte: 8 clock cells plus 8 data cells
`define DDSLC_CELLS_PER_BYTE 16
// bytes skipped after read gate when the delay is not bypassed
`define DDSLC_DELAY_BYTES 2
// bytes of preamble needed before lock is reported
`define DDSLC_LOCK_BYTES 2
// recovered clock to data frequency ratio while acquiring or idle
`define DDSLC_RATIO_IDLE 2
// counter width for cell counts
`define DDSLC_CNT_W 8
`endif

// [rtl/ddslc_pkg.sv]
`default_nettype none
package ddslc_pkg;
   typedef enum logic [2:0] {
      DDSLC_IDLE,
      DDSLC_DELAY,
      DDSLC_ACQUIRE,
      DDSLC_LOCKED,
      DDSLC_TRACK
   } ddslc_state_e;

   typedef struct packed {
      logic delay_bypass;
      logic preamble_polarity_select;
   } ddslc_cfg_s;

   typedef struct packed {
      logic lock_n;
      logic high_track_rate;
      logic cmp_sel_a;
      logic freq_compare_en;
   } ddslc_stat_s;

   typedef struct packed {
      ddslc_state_e st;
      logic [7:0] cnt;
      logic phase;
      logic lock_n;
      logic read_clk;
      logic read_data;
      logic sync_data;
      logic prev_data;
      logic absent;
   } ddslc_reg_s;
endpackage
`default_nettype wire

// [dv/ddslc_far_model.sv]
`default_nettype none
module ddslc_far_model (
   // clock
   input wire logic clk,
   // 0 silent, 1 preamble, 2 non-preamble field, 3 all-zero cells
   input wire logic [1:0] mode,
   input wire logic pol,
   // encoded cells toward the block
   output logic cell_valid,
   output logic cell_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph;
   logic [1:0] mode_q;
   logic pol_q;
   initial begin
      cell_valid = 1'b0;
      cell_bit = 1'b0;
      ph = 1'b0;
   end
   // mode and polarity change on the same falling edge this model runs on,
   // so a rising-edge copy fixes the order instead of racing the bench
   always @(posedge clk) begin
      mode_q <= mode;
      pol_q <= pol;
   end
   // one cell every second cycle; bit line scrambles between cells
   always @(negedge clk) begin
      if (mode_q != 2'h0 && !cell_valid) begin
         cell_valid <= 1'b1;
         cell_bit <= (mode_q == 2'h1) ? (ph ^ ~pol_q) : (mode_q == 2'h2);
      end else begin
         cell_valid <= 1'b0;
         cell_bit <= ~cell_bit;
      end
      ph <= (mode_q == 2'h0) ? 1'b0 : (ph ^ !cell_valid);
   end
endmodule
`default_nettype wire

// [dv/disk_data_separator_lock_control_tb_top.sv]
`default_nettype none
module disk_data_separator_lock_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ddslc_pkg::*;
   logic clk, rst_n, clk_en, read_gate, lock_commit, cell_valid, cell_bit, flag_seen;
   logic sync_data, read_clk, read_data, absent_clock_flag;
   logic [1:0] freq_ratio, mode;
   ddslc_cfg_s cfg;
   ddslc_stat_s stat;
   int err_total = 0, n_checks = 0, cells = 0, cyc = 0, tg = 0;
   ddslc_lock_ctrl #(.DELAY_BYTES(1), .LOCK_BYTES(1), .SEL_ON_GATE(1'b1)) uut (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .read_gate(read_gate),
      .lock_commit(lock_commit), .cfg(cfg), .cell_valid(cell_valid), .cell_bit(cell_bit),
      .stat(stat), .freq_ratio(freq_ratio), .sync_data(sync_data), .read_clk(read_clk),
      .read_data(read_data), .absent_clock_flag(absent_clock_flag));
   ddslc_far_model far (.clk(clk), .mode(mode), .pol(cfg.preamble_polarity_select),
      .cell_valid(cell_valid), .cell_bit(cell_bit));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // cycle ceiling well above the several hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cell_valid) cells++;
      if (absent_clock_flag === 1'b1) flag_seen = 1'b1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic do_reset();
      @(negedge clk);
      {rst_n, read_gate, lock_commit, mode} = 5'h00;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      flag_seen = 1'b0;
   endtask
   task automatic toggles();
      logic last;
      last = read_clk;
      tg = 0;
      repeat (8) begin
         @(negedge clk);
         if (read_clk !== last) tg++;
         last = read_clk;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic acquire(input logic byp, input logic pol, input logic [1:0] m, int exp_n);
      do_reset();
      cfg = '{byp, pol};
      read_gate = 1'b1;
      #1 check(stat.cmp_sel_a === 1'b1, "comparator select");
      repeat (2) @(negedge clk);
      check(stat.freq_compare_en === 1'b1 && freq_ratio === 2'h2, "acquire rate");
      cells = 0;
      mode = m;
      for (int i = 0; i < 400 && stat.lock_n !== 1'b0; i++) @(negedge clk);
      if (m == 2'h2) begin
         check(stat.lock_n === 1'b1 && flag_seen === 1'b0, "no preamble");
         check(read_data === 1'b0, "no decoding");
         read_gate = 1'b0;
         mode = 2'h1;
         repeat (2) @(negedge clk);
         read_gate = 1'b1;
         for (int i = 0; i < 400 && stat.lock_n !== 1'b0; i++) @(negedge clk);
         check(stat.lock_n === 1'b0, "lock after retry");
         return;
      end
      check(cells == exp_n, "lock cell count");
      check(sync_data === pol, "synchronized raw data");
      check(stat.freq_compare_en === 1'b0 && freq_ratio === 2'h2, "lock pre-commit");
      lock_commit = ~stat.lock_n;
      repeat (2) @(negedge clk);
      check(stat.high_track_rate === 1'b0 && freq_ratio === 2'h0, "low rate");
      toggles();
      check(tg == 4, "read clock at data rate");
      check(read_data === pol && flag_seen === 1'b0, "decoded preamble");
      mode = 2'h3;
      repeat (8) @(negedge clk);
      check(flag_seen === 1'b1 && read_data === 1'b0, "missing clock");
      read_gate = 1'b0;
      repeat (2) @(negedge clk);
      check(stat.lock_n === 1'b1 && stat.high_track_rate === 1'b1, "gate release");
      lock_commit = ~stat.lock_n;
      mode = 2'h0;
      toggles();
      check(tg == 8 && freq_ratio === 2'h2, "half reference clock");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {rst_n, read_gate, lock_commit, mode} = 5'h00;
      cfg = '{1'b1, 1'b0};
      clk_en = 1'b1;
      do_reset();
      toggles();
      check(tg == 8 && stat.lock_n === 1'b1 && freq_ratio === 2'h2, "idle");
      clk_en = 1'b0;
      toggles();
      check(tg == 0, "clock enable freeze");
      clk_en = 1'b1;
      acquire(1'b1, 1'b0, 2'h1, 16);
      acquire(1'b0, 1'b0, 2'h1, 32);
      acquire(1'b1, 1'b1, 2'h1, 16);
      acquire(1'b1, 1'b0, 2'h2, 0);
      conclude();
   end
endmodule
`default_nettype wire
